// ### bench/dual_timer_asserts.sv
// Purpose: Protocol and flag checks on the ports of the timer pair.
// Assumes: Zero wait state slave; irq acknowledge is a one-cycle pulse.
// Notes: Attached to the design by the bind after the module.
`timescale 1ns/10ps
module dual_timer_asserts
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer0IrqAck,
  input wire logic        timer1IrqAck,
  input wire logic        timer0IrqRequest,
  input wire logic        timer1IrqRequest,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_data_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_error_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_reset_quiet: assert property ($fell(rst) |-> !irq && !timer0IrqRequest && !timer1IrqRequest)
    else $error("interrupt output active after reset");
  a_ack_clears_zero: assert property (timer0IrqAck |-> ##2 !timer0IrqRequest)
    else $error("timer 0 request survived acknowledge");
  a_ack_clears_one: assert property (timer1IrqAck |-> ##2 !timer1IrqRequest)
    else $error("timer 1 request survived acknowledge");

  c_refused: cover property (pslverr);
  c_irq_rise: cover property ($rose(irq));
  c_req_zero: cover property ($rose(timer0IrqRequest));
  c_ack_one: cover property (timer1IrqAck && timer1IrqRequest);
endmodule // dual_timer_asserts

bind dual_up_timer_pair dual_timer_asserts dual_timer_asserts_inst (.clock, .rst, .psel, .penable,
  .prdata, .pready, .pslverr, .timer0IrqAck, .timer1IrqAck, .timer0IrqRequest,
  .timer1IrqRequest, .irq);

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the dual up timer pair.
// Assumes: Zero wait state slave; byte address is four times the index.
// Notes: Count windows run from one control write to the next.
`timescale 1ns/10ps
`include "dual_timer_regs.vh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        oscTick = 1'b0;
  logic        oscForce = 1'b0;
  logic        pinZero = 1'b1;
  logic        pinOne = 1'b1;
  logic        ack0 = 1'b0;
  logic        ack1 = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         req0;
  wire         req1;
  wire         irq;
  int          errCount = 0;
  int          nChecks = 0;
  int          cycles = 0;
  logic [31:0] q;
  logic        e;
  logic [7:0]  r;
  logic [7:0]  regs [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha8, 8'he7, 8'hf0, 8'hf2};

  dual_up_timer_pair dual_up_timer_pair_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscTick(oscTick),
    .extIrqPinZero(pinZero), .extIrqPinOne(pinOne), .timer0IrqAck(ack0),
    .timer1IrqAck(ack1), .timer0IrqRequest(req0), .timer1IrqRequest(req1), .irq(irq));

  initial forever #25 clock = ~clock;

  always @(posedge clock) oscTick <= oscForce | 1'($urandom_range(1, 0));

  task finalReport;
    if (errCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errCount++;
      finalReport();
    end
  end

  // One transfer; entered just after a rising edge, returns one idle edge after completion.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic s0, output logic [31:0] rq, output logic re);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'($urandom), d};
    pstrb <= {3'($urandom), s0};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, idx, d, 1'b1, rq, re);
  endtask

  task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, idx, 8'h00, 1'b1, rq, re);
    `CHK($sformatf("reg %h", idx), {24'h0, exp}, rq)
    `CHK($sformatf("err %h", idx), 1'b0, re)
  endtask

  // Loads a timer, lets it run for cyc clocks, stops it, then checks counts and status.
  task automatic runCase(input logic [7:0] md, input logic [7:0] hIdx, input logic [7:0] lIdx,
                         input logic [7:0] h, input logic [7:0] l, input logic [7:0] rf,
                         input int cyc, input logic [7:0] eh, input logic [7:0] el,
                         input logic [7:0] est);
    wr(8'h89, md);
    wr(hIdx, h);
    wr(lIdx, l);
    wr(8'h88, rf);
    repeat (cyc - 3) @(posedge clock);
    wr(8'h88, 8'h00);
    chk(hIdx, eh);
    chk(lIdx, el);
    chk(8'hf0, est);
    wr(8'hf1, 8'hff);
  endtask

  initial
  begin
    void'($urandom(32'he1510a65));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (regs[i]) chk(regs[i], 8'h00);
    apb(1'b0, 8'h00, 8'h00, 1'b1, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    repeat (4)
    begin
      for (int i = 8'h8a; i <= 8'h8d; i++)
      begin
        r = 8'($urandom);
        wr(8'(i), r);
        chk(8'(i), r);
      end
      apb(1'b1, 8'h8d, ~r, 1'b0, q, e);
      chk(8'h8d, r);
      r = 8'($urandom);
      wr(8'h89, r);
      chk(8'h89, r);
      wr(8'he7, r);
      chk(8'he7, r & 8'h77);
      wr(8'ha8, r);
      chk(8'ha8, r & 8'h8a);
    end
    wr(8'ha8, 8'h00);
    wr(8'h88, 8'ha0);
    chk(8'h88, 8'ha0);
    wr(8'h88, 8'h00);
    wr(8'hf1, 8'hff);
    r = {3'($urandom), 5'h00};
    runCase(8'h00, 8'h8d, 8'h8b, 8'hff, r | 8'h1f, 8'h40, 12, 8'h00, r, 8'h02);
    runCase(8'h01, 8'h8c, 8'h8a, 8'hff, 8'hff, 8'h10, 12, 8'h00, 8'h00, 8'h01);
    r = 8'($urandom);
    runCase(8'h02, 8'h8c, 8'h8a, r, 8'hff, 8'h10, 12, r, r, 8'h01);
    runCase(8'h01, 8'h8c, 8'h8a, 8'h12, 8'h34, 8'h00, 36, 8'h12, 8'h34, 8'h00);
    runCase(8'h30, 8'h8d, 8'h8b, 8'h56, 8'h78, 8'h40, 36, 8'h56, 8'h78, 8'h00);
    runCase(8'h10, 8'h8d, 8'h8b, 8'h00, 8'h00, 8'h40, 120, 8'h00, 8'h0a, 8'h00);
    pinOne <= 1'b0;
    runCase(8'h90, 8'h8d, 8'h8b, 8'h00, 8'h00, 8'h40, 24, 8'h00, 8'h00, 8'h00);
    pinOne <= 1'b1;
    runCase(8'h90, 8'h8d, 8'h8b, 8'h00, 8'h00, 8'h40, 24, 8'h00, 8'h02, 8'h00);
    pinZero <= 1'b0;
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hff);
    runCase(8'h1b, 8'h8c, 8'h8a, 8'h10, 8'h05, 8'h50, 12, 8'h11, 8'h05, 8'h00);
    chk(8'h8d, 8'h00);
    chk(8'h8b, 8'h00);
    runCase(8'h1b, 8'h8c, 8'h8a, 8'hff, 8'h05, 8'h50, 12, 8'h00, 8'h05, 8'h02);
    pinZero <= 1'b1;
    oscForce <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'he7, {1'b0, 3'(c), 4'h0});
      runCase(8'h05, 8'h8c, 8'h8a, 8'h00, 8'h00, 8'h10, 128, 8'h00, 8'(1 << c), 8'h00);
    end
    oscForce <= 1'b0;
    wr(8'ha8, 8'h8a);
    wr(8'hf2, 8'h02);
    wr(8'h89, 8'h10);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hff);
    wr(8'h88, 8'h40);
    repeat (14) @(posedge clock);
    `CHK("req1", 1'b1, req1)
    `CHK("irq", 1'b1, irq)
    ack1 <= 1'b1;
    @(posedge clock);
    ack1 <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("req1 after ack", 1'b0, req1)
    chk(8'h88, 8'h40);
    wr(8'hf2, 8'h01);
    repeat (2) @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    wr(8'hf2, 8'h02);
    repeat (2) @(posedge clock);
    `CHK("irq unmasked", 1'b1, irq)
    wr(8'hf1, 8'h02);
    repeat (2) @(posedge clock);
    `CHK("irq cleared", 1'b0, irq)
    wr(8'h88, 8'h20);
    repeat (2) @(posedge clock);
    `CHK("req0", 1'b1, req0)
    `CHK("req1 idle", 1'b0, req1)
    wr(8'ha8, 8'h0a);
    repeat (2) @(posedge clock);
    `CHK("req0 global off", 1'b0, req0)
    wr(8'h88, 8'h00);
    finalReport();
  end
endmodule // tb_top

// ### verilog/dual_timer_regs.vh
// Purpose: Register indices, field positions, reset values and timing counts of the timer pair.
// Assumes: APB byte address is four times a register index.
// Notes: Definitions only.
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

`define IDX_RUN_FLAG_CTRL      8'h88
`define IDX_MODE_CONFIG        8'h89
`define IDX_T0_COUNT_LOW       8'h8a
`define IDX_T1_COUNT_LOW       8'h8b
`define IDX_T0_COUNT_HIGH      8'h8c
`define IDX_T1_COUNT_HIGH      8'h8d
`define IDX_IRQ_ENABLE_PRIMARY 8'ha8
`define IDX_CLOCK_DIV_SELECT   8'he7
`define IDX_EVENT_STATUS       8'hf0
`define IDX_EVENT_CLEAR        8'hf1
`define IDX_EVENT_ENABLE       8'hf2

`define BIT_T1_FLAG            7
`define BIT_T1_RUN             6
`define BIT_T0_FLAG            5
`define BIT_T0_RUN             4
`define BIT_GLOBAL_IRQ_EN      7
`define BIT_T1_IRQ_EN          3
`define BIT_T0_IRQ_EN          1
`define BIT_T1_GATE            7
`define BIT_T1_CLK_SEL         6
`define BIT_T0_GATE            3
`define BIT_T0_CLK_SEL         2
`define MSB_T1_MODE            5
`define LSB_T1_MODE            4
`define MSB_T0_MODE            1
`define LSB_T0_MODE            0
`define MSB_T0_DIV             6
`define LSB_T0_DIV             4
`define MSB_T1_DIV             2
`define LSB_T1_DIV             0

`define RESET_BYTE             8'h00
`define RESET_DIV_CODE         3'h0

`define MODE_13BIT             2'h0
`define MODE_16BIT             2'h1
`define MODE_8BIT_RELOAD       2'h2
`define MODE_SPLIT             2'h3

`define CPU_DIVIDE             4'hc
`define OSC_DIV_MAX_CODE       3'h7

`endif

// ### verilog/dual_up_timer_pair.v
// Purpose: Two up-counting timers with APB registers, flags and event interrupt.
// Assumes: Pins and oscTick are synchronous to clock; irq acks are one-cycle pulses.
// Notes: A register write in the same cycle as a count step wins for counts.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "dual_timer_regs.vh"

// Functional notes
// - Two independent up timers, each with own overflow flag and interrupt enable.
// - Timer 0 has four modes; timer 1 has modes 0 to 2 only.
// - Count clock is CPU or oscillator based; gate pauses timer 0 via pin 0.
// - Mode 0 counts 13 bits; flag set on wrap from 0xFF1F.
// - Flag is firmware read/write; with its enable and the global enable set it requests interrupt service.
// - Mode 1 counts 16 bits; flag set on wrap from 0xFFFF.
// - Mode 2 low byte counts; on 0xFF wrap set flag and reload from high byte.
// - Mode 3 splits timer 0; high byte counts at CPU clock by 12 whenever run 1 is set.
// - In mode 3 only the timer 0 low byte is gated by pin 0.
// - Mode 3 low byte uses run 0 and flag 0; high byte run 1, flag 1.
// - While timer 0 is in mode 3, timer 1 counts without setting its flag.
// - Both flags reset to 0; cleared by interrupt service or firmware write.
// - Oscillator path divides by 128 down to 1 per 3-bit code.
// - Mode codes: 13-bit, 16-bit, 8-bit reload, split (timer 1 reserved).
// - Clock select 0 counts CPU by 12; 1 counts divided oscillator.
// - Gate bit gates timer 0 by pin zero and timer 1 by pin one.
module dual_up_timer_pair
(
  input  wire        clock,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        oscTick,
  input  wire        extIrqPinZero,
  input  wire        extIrqPinOne,
  input  wire        timer0IrqAck,
  input  wire        timer1IrqAck,
  output wire        timer0IrqRequest,
  output wire        timer1IrqRequest,
  output wire        irq
);

  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg         timer0OverflowFlag_ff;
  reg         timer1OverflowFlag_ff;
  reg         timer0Run_ff;
  reg         timer1Run_ff;
  reg  [7:0]  modeConfig_ff;
  reg  [2:0]  timer0OscDivider_ff;
  reg  [2:0]  timer1OscDivider_ff;
  reg         globalIrqEnable_ff;
  reg         timer0IrqEnable_ff;
  reg         timer1IrqEnable_ff;
  reg  [7:0]  timer0HighByte_ff;
  reg  [7:0]  timer0LowByte_ff;
  reg  [7:0]  timer1HighByte_ff;
  reg  [7:0]  timer1LowByte_ff;
  reg  [1:0]  eventStatus_ff;
  reg  [1:0]  eventEnable_ff;
  reg         timer0IrqRequest_ff;
  reg         timer1IrqRequest_ff;
  reg         irq_ff;
  reg  [7:0]  nxt_readByte;
  reg         nxt_mapped;
  reg  [7:0]  nxt_t0High;

  wire        cpuTick12;
  wire        t0OscTick;
  wire        t1OscTick;
  wire [1:0]  timer0ModeField;
  wire [1:0]  timer1ModeField;
  wire        timer0Split;
  wire        t0Tick;
  wire        t1Tick;
  wire        t0GateOk;
  wire        t1GateOk;
  wire        t0CountEn;
  wire        t1CountEn;
  wire        splitHighEn;
  wire        splitHighOverflow;
  wire [7:0]  t0CoreHigh;
  wire [7:0]  t0CoreLow;
  wire        t0CoreOverflow;
  wire [7:0]  t1CoreHigh;
  wire [7:0]  t1CoreLow;
  wire        t1CoreOverflow;
  wire        t0Event;
  wire        t1Event;
  wire        writeDone;
  wire        setupPhase;
  wire [7:0]  regIndex;
  wire [7:0]  wByte;
  wire        wrLane;
  wire        nxt_t0Flag;
  wire        nxt_t1Flag;
  wire [1:0]  nxt_status;
  wire        flagWrite;
  wire        clearWrite;

  assign regIndex   = paddr[9:2];
  assign wByte      = pwdata[7:0];
  assign wrLane     = pstrb[0];
  assign setupPhase = psel & ~penable;
  assign writeDone  = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // Decodes a completed, lane-enabled write to one register index.
  function regWriteHit;
    input       done;
    input [7:0] index;
    input [7:0] target;
    begin
      regWriteHit = done & (index == target);
    end
  endfunction

  assign flagWrite  = regWriteHit(writeDone & wrLane, regIndex, `IDX_RUN_FLAG_CTRL);
  assign clearWrite = regWriteHit(writeDone & wrLane, regIndex, `IDX_EVENT_CLEAR);

  assign timer0ModeField = modeConfig_ff[`MSB_T0_MODE:`LSB_T0_MODE];
  assign timer1ModeField = modeConfig_ff[`MSB_T1_MODE:`LSB_T1_MODE];
  assign timer0Split     = (timer0ModeField == `MODE_SPLIT);

  // Both oscillator dividers share one free-running count, so their ticks stay aligned.
  timer_prescaler u_prescaler
  (
    .clock     (clock),
    .rst       (rst),
    .oscTick   (oscTick),
    .t0DivCode (timer0OscDivider_ff),
    .t1DivCode (timer1OscDivider_ff),
    .cpuTick12 (cpuTick12),
    .t0OscTick (t0OscTick),
    .t1OscTick (t1OscTick)
  );

  assign t0Tick = modeConfig_ff[`BIT_T0_CLK_SEL] ? t0OscTick : cpuTick12;
  assign t1Tick = modeConfig_ff[`BIT_T1_CLK_SEL] ? t1OscTick : cpuTick12;

  assign t0GateOk = ~modeConfig_ff[`BIT_T0_GATE] | extIrqPinZero;
  assign t1GateOk = ~modeConfig_ff[`BIT_T1_GATE] | extIrqPinOne;

  assign t0CountEn = timer0Run_ff & t0Tick & t0GateOk;
  // Timer 1 code 11 is reserved and holds the count.
  assign t1CountEn = timer1Run_ff & t1Tick & t1GateOk & (timer1ModeField != `MODE_SPLIT);

  // Each core only proposes the next count; the registers below decide what lands.
  timer_count_core u_core0
  (
    .mode     (timer0ModeField),
    .countEn  (t0CountEn),
    .hiIn     (timer0HighByte_ff),
    .loIn     (timer0LowByte_ff),
    .hiOut    (t0CoreHigh),
    .loOut    (t0CoreLow),
    .overflow (t0CoreOverflow)
  );

  timer_count_core u_core1
  (
    .mode     (timer1ModeField),
    .countEn  (t1CountEn),
    .hiIn     (timer1HighByte_ff),
    .loIn     (timer1LowByte_ff),
    .hiOut    (t1CoreHigh),
    .loOut    (t1CoreLow),
    .overflow (t1CoreOverflow)
  );

  // Split high byte: fixed CPU-by-12 clock, run 1, never gated.
  assign splitHighEn       = timer0Split & timer1Run_ff & cpuTick12;
  assign splitHighOverflow = splitHighEn & (timer0HighByte_ff == 8'hff);

  always @*
  begin
    if (splitHighEn)
      nxt_t0High = timer0HighByte_ff + 8'h01;
    else if (timer0Split)
      nxt_t0High = timer0HighByte_ff;
    else
      nxt_t0High = t0CoreHigh;
  end

  assign t0Event = t0CoreOverflow;
  assign t1Event = timer0Split ? splitHighOverflow : t1CoreOverflow;

  // Hardware set wins over a firmware or service clear in the same cycle.
  assign nxt_t0Flag = t0Event
                    | (timer0OverflowFlag_ff & ~timer0IrqAck & ~flagWrite)
                    | (flagWrite & wByte[`BIT_T0_FLAG]);
  assign nxt_t1Flag = t1Event
                    | (timer1OverflowFlag_ff & ~timer1IrqAck & ~flagWrite)
                    | (flagWrite & wByte[`BIT_T1_FLAG]);

  // An event in the same cycle as a clear keeps its status bit set.
  assign nxt_status = {t1Event, t0Event}
                    | (eventStatus_ff & ~(clearWrite ? wByte[1:0] : 2'h0));

  always @*
  begin
    nxt_mapped   = 1'b1;
    nxt_readByte = 8'h00;
    case (regIndex)
      `IDX_RUN_FLAG_CTRL:
        nxt_readByte = {timer1OverflowFlag_ff, timer1Run_ff,
                        timer0OverflowFlag_ff, timer0Run_ff, 4'h0};
      `IDX_MODE_CONFIG:
        nxt_readByte = modeConfig_ff;
      `IDX_T0_COUNT_LOW:
        nxt_readByte = timer0LowByte_ff;
      `IDX_T1_COUNT_LOW:
        nxt_readByte = timer1LowByte_ff;
      `IDX_T0_COUNT_HIGH:
        nxt_readByte = timer0HighByte_ff;
      `IDX_T1_COUNT_HIGH:
        nxt_readByte = timer1HighByte_ff;
      `IDX_IRQ_ENABLE_PRIMARY:
        nxt_readByte = {globalIrqEnable_ff, 3'h0, timer1IrqEnable_ff,
                        1'b0, timer0IrqEnable_ff, 1'b0};
      `IDX_CLOCK_DIV_SELECT:
        nxt_readByte = {1'b0, timer0OscDivider_ff, 1'b0, timer1OscDivider_ff};
      `IDX_EVENT_STATUS:
        nxt_readByte = {6'h00, eventStatus_ff};
      `IDX_EVENT_CLEAR:
        nxt_readByte = 8'h00;
      `IDX_EVENT_ENABLE:
        nxt_readByte = {6'h00, eventEnable_ff};
      default:
        nxt_mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0)
      nxt_mapped = 1'b0;
  end

  // Bus answer: setup cycle prepares data, access phase completes in one cycle.
  always @(posedge clock)
  begin
    if (rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setupPhase;
      pslverr_ff <= setupPhase & ~nxt_mapped;
      if (setupPhase & ~pwrite)
        prdata_ff <= nxt_mapped ? {24'h000000, nxt_readByte} : 32'h00000000;
    end
  end

  // Count steps are assigned first so that a completing register write overrides them.
  always @(posedge clock)
  begin
    if (rst)
    begin
      timer0OverflowFlag_ff <= 1'b0;
      timer1OverflowFlag_ff <= 1'b0;
      timer0Run_ff          <= 1'b0;
      timer1Run_ff          <= 1'b0;
      modeConfig_ff         <= `RESET_BYTE;
      timer0OscDivider_ff   <= `RESET_DIV_CODE;
      timer1OscDivider_ff   <= `RESET_DIV_CODE;
      globalIrqEnable_ff    <= 1'b0;
      timer0IrqEnable_ff    <= 1'b0;
      timer1IrqEnable_ff    <= 1'b0;
      timer0HighByte_ff     <= `RESET_BYTE;
      timer0LowByte_ff      <= `RESET_BYTE;
      timer1HighByte_ff     <= `RESET_BYTE;
      timer1LowByte_ff      <= `RESET_BYTE;
      eventStatus_ff        <= 2'h0;
      eventEnable_ff        <= 2'h0;
      timer0IrqRequest_ff   <= 1'b0;
      timer1IrqRequest_ff   <= 1'b0;
      irq_ff                <= 1'b0;
    end
    else
    begin
      timer0OverflowFlag_ff <= nxt_t0Flag;
      timer1OverflowFlag_ff <= nxt_t1Flag;
      eventStatus_ff        <= nxt_status;
      timer0HighByte_ff     <= nxt_t0High;
      timer0LowByte_ff      <= t0CoreLow;
      timer1HighByte_ff     <= t1CoreHigh;
      timer1LowByte_ff      <= t1CoreLow;
      if (writeDone & wrLane)
      begin
        case (regIndex)
          `IDX_RUN_FLAG_CTRL:
          begin
            timer0Run_ff <= wByte[`BIT_T0_RUN];
            timer1Run_ff <= wByte[`BIT_T1_RUN];
          end
          `IDX_MODE_CONFIG:
            modeConfig_ff <= wByte;
          `IDX_T0_COUNT_LOW:
            timer0LowByte_ff <= wByte;
          `IDX_T1_COUNT_LOW:
            timer1LowByte_ff <= wByte;
          `IDX_T0_COUNT_HIGH:
            timer0HighByte_ff <= wByte;
          `IDX_T1_COUNT_HIGH:
            timer1HighByte_ff <= wByte;
          `IDX_IRQ_ENABLE_PRIMARY:
          begin
            globalIrqEnable_ff <= wByte[`BIT_GLOBAL_IRQ_EN];
            timer0IrqEnable_ff <= wByte[`BIT_T0_IRQ_EN];
            timer1IrqEnable_ff <= wByte[`BIT_T1_IRQ_EN];
          end
          `IDX_CLOCK_DIV_SELECT:
          begin
            timer0OscDivider_ff <= wByte[`MSB_T0_DIV:`LSB_T0_DIV];
            timer1OscDivider_ff <= wByte[`MSB_T1_DIV:`LSB_T1_DIV];
          end
          `IDX_EVENT_ENABLE:
            eventEnable_ff <= wByte[1:0];
          default:
            eventEnable_ff <= eventEnable_ff;
        endcase
      end
      // A request drops on the same edge at which its acknowledge clears the flag.
      timer0IrqRequest_ff <= nxt_t0Flag & timer0IrqEnable_ff & globalIrqEnable_ff;
      timer1IrqRequest_ff <= nxt_t1Flag & timer1IrqEnable_ff & globalIrqEnable_ff;
      // The summary line follows the next status so that it rises with the event edge.
      irq_ff              <= |(nxt_status & eventEnable_ff);
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign timer0IrqRequest = timer0IrqRequest_ff;
  assign timer1IrqRequest = timer1IrqRequest_ff;
  assign irq              = irq_ff;

endmodule // dual_up_timer_pair

// ### verilog/timer_count_core.v
// Purpose: Next count and overflow of one timer for one count step.
// Assumes: The caller registers the outputs and handles split high byte.
// Notes: In split mode this core only runs the low byte as a plain 8-bit counter.
`timescale 1ns/10ps
`include "dual_timer_regs.vh"

module timer_count_core
(
  input  wire [1:0] mode,
  input  wire       countEn,
  input  wire [7:0] hiIn,
  input  wire [7:0] loIn,
  output reg  [7:0] hiOut,
  output reg  [7:0] loOut,
  output reg        overflow
);

  always @*
  begin
    hiOut    = hiIn;
    loOut    = loIn;
    overflow = 1'b0;
    if (countEn)
    begin
      case (mode)
        `MODE_13BIT:
        begin
          // Only five low bits count; the upper three stay as written.
          loOut[4:0] = loIn[4:0] + 5'h01;
          if (loIn[4:0] == 5'h1f)
            hiOut = hiIn + 8'h01;
          overflow = (hiIn == 8'hff) && (loIn[4:0] == 5'h1f);
        end
        `MODE_16BIT:
        begin
          {hiOut, loOut} = {hiIn, loIn} + 16'h0001;
          overflow = ({hiIn, loIn} == 16'hffff);
        end
        `MODE_8BIT_RELOAD:
        begin
          overflow = (loIn == 8'hff);
          loOut    = overflow ? hiIn : loIn + 8'h01;
        end
        `MODE_SPLIT:
        begin
          loOut    = loIn + 8'h01;
          overflow = (loIn == 8'hff);
        end
        default:
        begin
          loOut = loIn;
        end
      endcase
    end
  end

endmodule // timer_count_core

// ### verilog/timer_prescaler.v
// Purpose: Makes the CPU-clock-by-12 tick and the two oscillator divider ticks.
// Assumes: oscTick is a one-cycle pulse per oscillator period, synchronous to clock.
// Notes: Divider codes 0 to 7 give division by 128 down to 1.
`timescale 1ns/10ps
`include "dual_timer_regs.vh"

module timer_prescaler
(
  input  wire       clock,
  input  wire       rst,
  input  wire       oscTick,
  input  wire [2:0] t0DivCode,
  input  wire [2:0] t1DivCode,
  output wire       cpuTick12,
  output wire       t0OscTick,
  output wire       t1OscTick
);

  reg [3:0] cpuCount_ff;
  reg [6:0] oscCount_ff;

  // A code selects how many low bits of the free oscillator count must be all ones.
  function divTick;
    input [6:0] count;
    input [2:0] code;
    reg   [6:0] mask;
    begin
      mask    = 7'h7f >> code;
      divTick = ((count & mask) == mask);
    end
  endfunction

  always @(posedge clock)
  begin
    if (rst)
    begin
      cpuCount_ff <= 4'h0;
      oscCount_ff <= 7'h00;
    end
    else
    begin
      if (cpuCount_ff == (`CPU_DIVIDE - 4'h1))
        cpuCount_ff <= 4'h0;
      else
        cpuCount_ff <= cpuCount_ff + 4'h1;
      if (oscTick)
        oscCount_ff <= oscCount_ff + 7'h01;
    end
  end

  assign cpuTick12 = (cpuCount_ff == (`CPU_DIVIDE - 4'h1));
  assign t0OscTick = oscTick & divTick(oscCount_ff, t0DivCode);
  assign t1OscTick = oscTick & divTick(oscCount_ff, t1DivCode);

endmodule // timer_prescaler
